// file: rtcbk_top.sv
// Purpose: Backup-domain real-time clock with BCD calendar, two alarms,
//          wakeup downcounter, user backup words and a backup SRAM.
// Assumes: Clock-source ticks and strobes are single-cycle, synchronous.
// Notes:   Low-power state inputs never stop the counting logic.
`timescale 1ns/100ps
`default_nettype none
module rtcbk_top
  import rtcbk_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SLOW_XTAL_TICK,
  input  wire logic        LOW_RC_TICK,
  input  wire logic        FAST_EXT_TICK,
  input  wire logic [1:0]  CLK_SEL,
  input  wire logic        PRESC_WR,
  input  wire logic [19:0] PRESC_WDATA,
  input  wire logic        REF_EN,
  input  wire logic        REF_60HZ,
  input  wire logic        REF_TICK,
  input  wire logic        CAL_EN,
  input  wire logic        FMT_12H,
  input  wire logic        SET_STB,
  input  wire logic [7:0]  SET_SEC,
  input  wire logic [7:0]  SET_MIN,
  input  wire logic [7:0]  SET_HOUR,
  input  wire logic        SET_PM,
  input  wire logic [2:0]  SET_WDAY,
  input  wire logic [7:0]  SET_DATE,
  input  wire logic [7:0]  SET_MON,
  input  wire logic [7:0]  SET_YEAR,
  input  wire logic [1:0]  ALM_EN,
  input  wire logic [15:0] ALMA_SEC_MIN,
  input  wire logic [16:0] ALMA_PM_HOUR_DATE,
  input  wire logic [3:0]  ALMA_MASK,
  input  wire logic [15:0] ALMB_SEC_MIN,
  input  wire logic [16:0] ALMB_PM_HOUR_DATE,
  input  wire logic [3:0]  ALMB_MASK,
  input  wire logic        WUT_EN,
  input  wire logic [2:0]  WUT_SEL,
  input  wire logic [15:0] WUT_RELOAD,
  input  wire logic        TAMPER_IN,
  input  wire logic        TSTAMP_IN,
  input  wire logic        STOP_MODE,
  input  wire logic        STANDBY_MODE,
  input  wire logic        BATTERY_MODE,
  input  wire logic        EXTERNAL_RESET_PIN,
  input  wire logic        INDEPENDENT_WATCHDOG_RST,
  input  wire logic        WAKEUP_PIN,
  input  wire logic        BKP_WR,
  input  wire logic        BKP_RD,
  input  wire logic [4:0]  BKP_ADDR,
  input  wire logic [31:0] BKP_WDATA,
  input  wire logic        SRAM_ON,
  input  wire logic        SRAM_OFF,
  input  wire logic        SRAM_WR,
  input  wire logic        SRAM_RD,
  input  wire logic [9:0]  SRAM_ADDR,
  input  wire logic [31:0] SRAM_WDATA,
  output logic [7:0]       SEC,
  output logic [7:0]       MIN,
  output logic [7:0]       HOUR,
  output logic             PM,
  output logic [2:0]       WDAY,
  output logic [7:0]       DATE,
  output logic [7:0]       MON,
  output logic [7:0]       YEAR,
  output logic             CAL_OUT,
  output logic [4:0]       EXTERNAL_EVENT_LINES,
  output logic             STOP_WAKE,
  output logic             STANDBY_EXIT,
  output logic [31:0]      BKP_RDATA,
  output logic             SRAM_ENABLED,
  output logic [31:0]      SRAM_RDATA
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] != 4'h9) return {v[7:4], v[3:0] + 4'h1};
    if (v[7:4] == 4'h9) return 8'h00;
    return {v[7:4] + 4'h1, 4'h0};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  // Field compare for one alarm; a set mask bit drops that field.
  function automatic logic alarm_hit(input logic [15:0] sm,
                                     input logic [16:0] phd,
                                     input logic [3:0]  msk,
                                     input logic [32:0] now);
    return ((msk & MSK_SEC)  != 4'h0 || sm[7:0]    == now[7:0])
        && ((msk & MSK_MIN)  != 4'h0 || sm[15:8]   == now[15:8])
        && ((msk & MSK_HOUR) != 4'h0 || phd[16:8]  == now[24:16])
        && ((msk & MSK_DATE) != 4'h0 || phd[7:0]   == now[32:25]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [6:0]  fast_cnt_reg;
  logic        fast_pulse_reg;
  logic        rtc_tick;
  logic [19:0] presc_load_reg;
  logic [19:0] presc_cnt_reg;
  logic [5:0]  ref_cnt_reg;
  logic        sec_tick;
  logic [4:0]  cal_cnt_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fast_cnt_reg   <= 7'h00;
      fast_pulse_reg <= 1'b0;
    end else begin
      fast_pulse_reg <= FAST_EXT_TICK && fast_cnt_reg == FAST_DIV_LAST;
      if (FAST_EXT_TICK) begin
        fast_cnt_reg <= fast_cnt_reg + 7'h01;
      end
    end
  end

  always_comb begin
    unique case (CLK_SEL)
      CSEL_SLOW_XTAL: rtc_tick = SLOW_XTAL_TICK;
      CSEL_LOW_RC:    rtc_tick = LOW_RC_TICK;
      CSEL_FAST_DIV:  rtc_tick = fast_pulse_reg;
      default:        rtc_tick = 1'b0;
    endcase
  end

  // The reference source replaces the prescaler only as the seconds source.
  assign sec_tick = REF_EN
    ? (REF_TICK && ref_cnt_reg == (REF_60HZ ? REF60_LAST : REF50_LAST))
    : (rtc_tick && presc_cnt_reg == 20'h00000);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      presc_load_reg <= PRESC_RST;
      presc_cnt_reg  <= PRESC_RST;
    end else begin
      if (PRESC_WR) begin
        presc_load_reg <= PRESC_WDATA;
        presc_cnt_reg  <= PRESC_WDATA;
      end else if (rtc_tick) begin
        presc_cnt_reg <= (presc_cnt_reg == 20'h00000) ? presc_load_reg
                                                       : presc_cnt_reg - 20'h00001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST || !REF_EN) begin
      ref_cnt_reg <= 6'h00;
    end else if (sec_tick) begin
      ref_cnt_reg <= 6'h00;
    end else if (REF_TICK) begin
      ref_cnt_reg <= ref_cnt_reg + 6'h01;
    end
  end

  // 64 counting ticks per period: 512 Hz from a 32.768 kHz source.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cal_cnt_reg <= 5'h00;
      CAL_OUT     <= 1'b0;
    end else if (!CAL_EN) begin
      CAL_OUT <= 1'b0;
    end else if (rtc_tick) begin
      cal_cnt_reg <= cal_cnt_reg + 5'h01;
      if (cal_cnt_reg == CAL_HALF) begin
        CAL_OUT <= !CAL_OUT;
      end
    end
  end

  AST_CAL_TOGGLE: assert property (@(posedge CORE_CLK) disable iff (RST)
    CAL_EN && $past(CAL_EN) && CAL_OUT != $past(CAL_OUT)
      |-> $past(rtc_tick) && $past(cal_cnt_reg) == CAL_HALF)
    else $error("calibration output toggled off its count");
  AST_PRESC_RELOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
    !REF_EN && !PRESC_WR && sec_tick |=> presc_cnt_reg == presc_load_reg)
    else $error("prescaler not reloaded after seconds tick");

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] sec_next, min_next, hour_next, date_next, mon_next, year_next;
  logic [2:0] wday_next;
  logic       pm_next, day_carry, cal_upd_reg;

  always_comb begin
    sec_next = bcd_inc(SEC);
    min_next = MIN;
    hour_next = HOUR;
    pm_next = PM;
    wday_next = WDAY;
    date_next = DATE;
    mon_next = MON;
    year_next = YEAR;
    day_carry = 1'b0;
    if (SEC == 8'h59) begin
      sec_next = 8'h00;
      min_next = bcd_inc(MIN);
      if (MIN == 8'h59) begin
        min_next = 8'h00;
        hour_next = bcd_inc(HOUR);
        if (FMT_12H) begin
          if (HOUR == 8'h12) hour_next = 8'h01;
          if (HOUR == 8'h11) begin
            pm_next = !PM;
            day_carry = PM;
          end
        end else if (HOUR == 8'h23) begin
          hour_next = 8'h00;
          day_carry = 1'b1;
        end
      end
    end
    if (day_carry) begin
      wday_next = (WDAY == 3'h7) ? 3'h1 : WDAY + 3'h1;
      date_next = bcd_inc(DATE);
      if (DATE == month_days(MON, YEAR)) begin
        date_next = 8'h01;
        mon_next = (MON == 8'h12) ? 8'h01 : bcd_inc(MON);
        if (MON == 8'h12) year_next = bcd_inc(YEAR);
      end
    end
  end

  // Reset only by the backup-domain reset; Stop and Standby do not halt it.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      {SEC, MIN, HOUR, PM} <= {SEC_RST, MIN_RST, HOUR_RST, 1'b0};
      {WDAY, DATE, MON, YEAR} <= {WDAY_RST, DATE_RST, MON_RST, YEAR_RST};
      cal_upd_reg <= 1'b0;
    end else begin
      cal_upd_reg <= sec_tick && !SET_STB;
      if (SET_STB) begin
        {SEC, MIN, HOUR, PM} <= {SET_SEC, SET_MIN, SET_HOUR, SET_PM};
        {WDAY, DATE, MON, YEAR} <= {SET_WDAY, SET_DATE, SET_MON, SET_YEAR};
      end else if (sec_tick) begin
        {SEC, MIN, HOUR, PM} <= {sec_next, min_next, hour_next, pm_next};
        {WDAY, DATE, MON, YEAR} <= {wday_next, date_next, mon_next, year_next};
      end
    end
  end

  AST_SEC_RANGE: assert property (@(posedge CORE_CLK) disable iff (RST)
    !$past(SET_STB) |-> SEC[3:0] <= 4'h9 && SEC[7:4] <= 4'h5)
    else $error("seconds left BCD range");
  AST_MONTH_END: assert property (@(posedge CORE_CLK) disable iff (RST)
    sec_tick && !SET_STB && day_carry && DATE == month_days(MON, YEAR)
      |=> DATE == 8'h01)
    else $error("date did not roll at month end");
  AST_CARRY: assert property (@(posedge CORE_CLK) disable iff (RST)
    sec_tick && !SET_STB && SEC == 8'h59 && MIN != 8'h59
      |=> SEC == 8'h00 && MIN == bcd_inc($past(MIN)))
    else $error("seconds did not carry into minutes");

  ////////////////////////////////////////////////////////////////////////
  logic [3:0]  wut_div_reg;
  logic [15:0] wut_cnt_reg;
  logic        wut_ce, wut_evt, wut_en_d_reg, tamper_d_reg, tstamp_d_reg;
  logic        wake_pin_d_reg;
  logic [4:0]  evt;
  logic [32:0] now;

  // Divided ticks give 16, 8, 4 or 2 source periods; code 4 counts seconds.
  always_comb begin
    unique case (WUT_SEL)
      3'h0:     wut_ce = rtc_tick && wut_div_reg == 4'hF;
      3'h1:     wut_ce = rtc_tick && wut_div_reg[2:0] == 3'h7;
      3'h2:     wut_ce = rtc_tick && wut_div_reg[1:0] == 2'h3;
      3'h3:     wut_ce = rtc_tick && wut_div_reg[0];
      WSEL_SEC: wut_ce = sec_tick;
      default:  wut_ce = 1'b0;
    endcase
  end

  assign wut_evt = WUT_EN && wut_en_d_reg && wut_ce && wut_cnt_reg == 16'h0000;
  assign now = {DATE, PM, HOUR, MIN, SEC};
  assign evt = {TSTAMP_IN && !tstamp_d_reg, TAMPER_IN && !tamper_d_reg, wut_evt,
                cal_upd_reg && ALM_EN[1]
                  && alarm_hit(ALMB_SEC_MIN, ALMB_PM_HOUR_DATE, ALMB_MASK, now),
                cal_upd_reg && ALM_EN[0]
                  && alarm_hit(ALMA_SEC_MIN, ALMA_PM_HOUR_DATE, ALMA_MASK, now)};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wut_div_reg  <= 4'h0;
      wut_cnt_reg  <= WUT_RELOAD_RST;
      wut_en_d_reg <= 1'b0;
    end else begin
      wut_en_d_reg <= WUT_EN;
      if (rtc_tick) wut_div_reg <= wut_div_reg + 4'h1;
      if (WUT_EN && !wut_en_d_reg) begin
        wut_cnt_reg <= WUT_RELOAD;
      end else if (WUT_EN && wut_ce) begin
        wut_cnt_reg <= (wut_cnt_reg == 16'h0000) ? WUT_RELOAD
                                                  : wut_cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      {tamper_d_reg, tstamp_d_reg, wake_pin_d_reg} <= 3'h0;
      EXTERNAL_EVENT_LINES <= 5'h00;
      STOP_WAKE    <= 1'b0;
      STANDBY_EXIT <= 1'b0;
    end else begin
      {tamper_d_reg, tstamp_d_reg, wake_pin_d_reg} <= {TAMPER_IN, TSTAMP_IN, WAKEUP_PIN};
      EXTERNAL_EVENT_LINES <= evt;
      STOP_WAKE <= STOP_MODE && !BATTERY_MODE && evt != 5'h00;
      STANDBY_EXIT <= STANDBY_MODE && !BATTERY_MODE
        && (evt != 5'h00 || EXTERNAL_RESET_PIN || INDEPENDENT_WATCHDOG_RST
            || (WAKEUP_PIN && !wake_pin_d_reg));
    end
  end

  AST_WUT_RELOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
    wut_evt |=> wut_cnt_reg == $past(WUT_RELOAD) ##0 EXTERNAL_EVENT_LINES[EV_WAKE])
    else $error("wakeup counter did not reload and signal");
  AST_EVT_LINE: assert property (@(posedge CORE_CLK) disable iff (RST)
    evt[EV_ALMA] || evt[EV_ALMB] |=> EXTERNAL_EVENT_LINES[EV_ALMA] ||
      EXTERNAL_EVENT_LINES[EV_ALMB])
    else $error("alarm event missing from event lines");
  AST_BATTERY_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
    BATTERY_MODE |=> !STANDBY_EXIT && !STOP_WAKE)
    else $error("battery operation ended by an event");
  AST_STANDBY_EXIT: assert property (@(posedge CORE_CLK) disable iff (RST)
    STANDBY_MODE && !BATTERY_MODE && evt[EV_TAMPER] |=> STANDBY_EXIT)
    else $error("tamper event did not end standby");

  ////////////////////////////////////////////////////////////////////////
  // Neither array has a reset: contents survive every reset and Standby.
  logic [31:0] bkp_mem  [BKP_WORDS];
  logic [31:0] sram_mem [SRAM_WORDS];

  always_ff @(posedge CORE_CLK) begin
    if (BKP_WR && BKP_ADDR < 5'(BKP_WORDS)) begin
      bkp_mem[BKP_ADDR] <= BKP_WDATA;
    end
    if (SRAM_WR && SRAM_ENABLED) begin
      sram_mem[SRAM_ADDR] <= SRAM_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      BKP_RDATA    <= 32'h00000000;
      SRAM_RDATA   <= 32'h00000000;
      SRAM_ENABLED <= 1'b0;
    end else begin
      if (SRAM_ON) SRAM_ENABLED <= 1'b1;
      else if (SRAM_OFF) SRAM_ENABLED <= 1'b0;
      if (BKP_RD) begin
        BKP_RDATA <= (BKP_ADDR < 5'(BKP_WORDS)) ? bkp_mem[BKP_ADDR] : 32'h00000000;
      end
      if (SRAM_RD) begin
        SRAM_RDATA <= SRAM_ENABLED ? sram_mem[SRAM_ADDR] : 32'h00000000;
      end
    end
  end

  AST_SRAM_GATED: assert property (@(posedge CORE_CLK) disable iff (RST)
    SRAM_RD && !SRAM_ENABLED |=> SRAM_RDATA == 32'h00000000)
    else $error("disabled backup SRAM returned data");
endmodule
`default_nettype wire

// file: rtcbk_pkg.sv
// Purpose: Constants shared by the backup-domain real-time clock.
// Assumes: A 200 MHz core clock and single-cycle clock-source tick inputs.
// Notes:   Offsets, reset values, counts, select codes and masks only; no logic.
`default_nettype none
package rtcbk_pkg;
  localparam int          CORE_MHZ      = 200;
  localparam logic [19:0] PRESC_RST     = 20'h07FFF;
  localparam logic [6:0]  FAST_DIV_LAST = 7'h7F;
  localparam logic [4:0]  CAL_HALF      = 5'h1F;
  localparam logic [5:0]  REF50_LAST    = 6'h31;
  localparam logic [5:0]  REF60_LAST    = 6'h3B;
  localparam logic [15:0] WUT_RELOAD_RST = 16'hFFFF;
  localparam logic [1:0]  CSEL_SLOW_XTAL = 2'h0;
  localparam logic [1:0]  CSEL_LOW_RC    = 2'h1;
  localparam logic [1:0]  CSEL_FAST_DIV  = 2'h2;
  localparam logic [2:0]  WSEL_SEC       = 3'h4;
  localparam logic [7:0]  SEC_RST   = 8'h00;
  localparam logic [7:0]  MIN_RST   = 8'h00;
  localparam logic [7:0]  HOUR_RST  = 8'h00;
  localparam logic [2:0]  WDAY_RST  = 3'h1;
  localparam logic [7:0]  DATE_RST  = 8'h01;
  localparam logic [7:0]  MON_RST   = 8'h01;
  localparam logic [7:0]  YEAR_RST  = 8'h00;
  localparam int          BKP_WORDS  = 20;
  localparam int          SRAM_WORDS = 1024;
  localparam int          EV_ALMA    = 0;
  localparam int          EV_ALMB    = 1;
  localparam int          EV_WAKE    = 2;
  localparam int          EV_TAMPER  = 3;
  localparam int          EV_TSTAMP  = 4;
  localparam logic [3:0]  MSK_SEC    = 4'h1;
  localparam logic [3:0]  MSK_MIN    = 4'h2;
  localparam logic [3:0]  MSK_HOUR   = 4'h4;
  localparam logic [3:0]  MSK_DATE   = 4'h8;
endpackage
`default_nettype wire

// file: rtcbk_top_tb.sv
// Purpose: Self-checking bench for the backup-domain real-time clock.
// Assumes: With the prescaler reload at zero, each slow or RC source tick is one second, and 128 fast ticks are one.
// Notes:   Event pulses are caught by sticky monitors sampled mid-cycle.
`timescale 1ns/100ps
`default_nettype none
module rtcbk_top_tb
  import rtcbk_pkg::*;
;
  logic        CORE_CLK, RST, SLOW_XTAL_TICK, LOW_RC_TICK, FAST_EXT_TICK, PRESC_WR;
  logic [1:0]  CLK_SEL, ALM_EN;
  logic [19:0] PRESC_WDATA;
  logic        REF_EN, REF_60HZ, REF_TICK, CAL_EN, FMT_12H, SET_STB, SET_PM;
  logic [7:0]  SET_SEC, SET_MIN, SET_HOUR, SET_DATE, SET_MON, SET_YEAR;
  logic [2:0]  SET_WDAY, WUT_SEL, WDAY;
  logic [15:0] ALMA_SEC_MIN, ALMB_SEC_MIN, WUT_RELOAD;
  logic [16:0] ALMA_PM_HOUR_DATE, ALMB_PM_HOUR_DATE;
  logic [3:0]  ALMA_MASK, ALMB_MASK;
  logic        WUT_EN, TAMPER_IN, TSTAMP_IN, STOP_MODE, STANDBY_MODE, BATTERY_MODE;
  logic        EXTERNAL_RESET_PIN, INDEPENDENT_WATCHDOG_RST, WAKEUP_PIN;
  logic        BKP_WR, BKP_RD, SRAM_ON, SRAM_OFF, SRAM_WR, SRAM_RD;
  logic [4:0]  BKP_ADDR, EXTERNAL_EVENT_LINES, ev_seen;
  logic [9:0]  SRAM_ADDR;
  logic [31:0] BKP_WDATA, SRAM_WDATA, BKP_RDATA, SRAM_RDATA;
  logic [7:0]  SEC, MIN, HOUR, DATE, MON, YEAR;
  logic        PM, CAL_OUT, STOP_WAKE, STANDBY_EXIT, SRAM_ENABLED, stop_seen, sbx_seen;
  int          n_errors, total_checks, wake_cnt;

  rtcbk_top i_dut (
    .CORE_CLK, .RST, .SLOW_XTAL_TICK, .LOW_RC_TICK, .FAST_EXT_TICK, .CLK_SEL,
    .PRESC_WR, .PRESC_WDATA, .REF_EN, .REF_60HZ, .REF_TICK, .CAL_EN, .FMT_12H,
    .SET_STB, .SET_SEC, .SET_MIN, .SET_HOUR, .SET_PM, .SET_WDAY, .SET_DATE,
    .SET_MON, .SET_YEAR, .ALM_EN, .ALMA_SEC_MIN, .ALMA_PM_HOUR_DATE, .ALMA_MASK,
    .ALMB_SEC_MIN, .ALMB_PM_HOUR_DATE, .ALMB_MASK, .WUT_EN, .WUT_SEL, .WUT_RELOAD,
    .TAMPER_IN, .TSTAMP_IN, .STOP_MODE, .STANDBY_MODE, .BATTERY_MODE,
    .EXTERNAL_RESET_PIN, .INDEPENDENT_WATCHDOG_RST, .WAKEUP_PIN, .BKP_WR, .BKP_RD,
    .BKP_ADDR, .BKP_WDATA, .SRAM_ON, .SRAM_OFF, .SRAM_WR, .SRAM_RD, .SRAM_ADDR,
    .SRAM_WDATA, .SEC, .MIN, .HOUR, .PM, .WDAY, .DATE, .MON, .YEAR, .CAL_OUT,
    .EXTERNAL_EVENT_LINES, .STOP_WAKE, .STANDBY_EXIT, .BKP_RDATA, .SRAM_ENABLED,
    .SRAM_RDATA
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 CORE_CLK = ~CORE_CLK;

  // One-cycle pulses are accumulated here so that checks need no exact phase.
  always @(negedge CORE_CLK) begin
    ev_seen = ev_seen | EXTERNAL_EVENT_LINES;
    stop_seen = stop_seen | STOP_WAKE;
    sbx_seen = sbx_seen | STANDBY_EXIT;
    wake_cnt = wake_cnt + int'(EXTERNAL_EVENT_LINES[EV_WAKE]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  task automatic clr();
    @(posedge CORE_CLK);
    ev_seen = 5'h00;
    stop_seen = 1'b0;
    sbx_seen = 1'b0;
    wake_cnt = 0;
  endtask

  task automatic tick(input int src, input int n);
    repeat (n) begin
      @(posedge CORE_CLK);
      SLOW_XTAL_TICK <= (src == 0);
      LOW_RC_TICK <= (src == 1);
      FAST_EXT_TICK <= (src == 2);
      REF_TICK <= (src == 3);
      @(posedge CORE_CLK);
      {SLOW_XTAL_TICK, LOW_RC_TICK, FAST_EXT_TICK, REF_TICK} <= 4'h0;
    end
    cyc(4);
  endtask

  task automatic chk_rst();
    chk({HOUR, MIN, SEC}, {HOUR_RST, MIN_RST, SEC_RST});
    chk({PM, WDAY}, {1'b0, WDAY_RST});
    chk({DATE, MON, YEAR}, {DATE_RST, MON_RST, YEAR_RST});
    chk({CAL_OUT, SRAM_ENABLED, EXTERNAL_EVENT_LINES}, 7'h00);
  endtask

  task automatic do_reset();
    @(posedge CORE_CLK);
    RST <= 1'b1;
    cyc(12);
    RST <= 1'b0;
    cyc(1);
  endtask

  // Sets the calendar, advances one second and compares all fields.
  task automatic cal(input logic [23:0] hms, input logic [3:0] pwd, input logic [23:0] dmy,
                     input logic [23:0] ehms, input logic [3:0] epwd, input logic [23:0] edmy);
    @(posedge CORE_CLK);
    {SET_HOUR, SET_MIN, SET_SEC} <= hms;
    {SET_PM, SET_WDAY} <= pwd;
    {SET_DATE, SET_MON, SET_YEAR} <= dmy;
    SET_STB <= 1'b1;
    @(posedge CORE_CLK);
    SET_STB <= 1'b0;
    cyc(2);
    tick(0, 1);
    chk({HOUR, MIN, SEC}, ehms);
    chk({PM, WDAY}, epwd);
    chk({DATE, MON, YEAR}, edmy);
  endtask

  task automatic acc(input logic sram, input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    BKP_WR <= !sram && wr;
    BKP_RD <= !sram && !wr;
    SRAM_WR <= sram && wr;
    SRAM_RD <= sram && !wr;
    BKP_ADDR <= a[4:0];
    SRAM_ADDR <= a;
    BKP_WDATA <= d;
    SRAM_WDATA <= d;
    @(posedge CORE_CLK);
    {BKP_WR, BKP_RD, SRAM_WR, SRAM_RD} <= 4'h0;
    cyc(2);
  endtask

  task automatic sram_ctl(input logic on, input logic off);
    @(posedge CORE_CLK);
    {SRAM_ON, SRAM_OFF} <= {on, off};
    @(posedge CORE_CLK);
    {SRAM_ON, SRAM_OFF} <= 2'h0;
    cyc(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A hung run is cut short here and counted as a mismatch.
  initial begin
    #480000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    {CORE_CLK, SLOW_XTAL_TICK, LOW_RC_TICK, FAST_EXT_TICK, PRESC_WR, PRESC_WDATA} = '0;
    {RST, CLK_SEL, REF_EN, REF_60HZ, REF_TICK, CAL_EN, FMT_12H, SET_STB, SET_PM} = '0;
    {SET_SEC, SET_MIN, SET_HOUR, SET_DATE, SET_MON, SET_YEAR, SET_WDAY} = '0;
    {ALM_EN, ALMA_SEC_MIN, ALMA_PM_HOUR_DATE, ALMA_MASK, ALMB_SEC_MIN} = '0;
    {ALMB_PM_HOUR_DATE, ALMB_MASK, WUT_EN, WUT_SEL, WUT_RELOAD, TAMPER_IN} = '0;
    {TSTAMP_IN, STOP_MODE, STANDBY_MODE, BATTERY_MODE, EXTERNAL_RESET_PIN} = '0;
    {INDEPENDENT_WATCHDOG_RST, WAKEUP_PIN, BKP_WR, BKP_RD, BKP_ADDR, BKP_WDATA} = '0;
    {SRAM_ON, SRAM_OFF, SRAM_WR, SRAM_RD, SRAM_ADDR, SRAM_WDATA} = '0;
    {n_errors, total_checks, wake_cnt, ev_seen, stop_seen, sbx_seen} = '0;
    CLK_SEL = CSEL_SLOW_XTAL;
    do_reset();
    chk_rst();
    CAL_EN <= 1'b1;
    tick(0, 31);
    chk(CAL_OUT, 1'b0);
    tick(0, 1);
    chk(CAL_OUT, 1'b1);
    tick(0, 32735);
    chk(SEC, SEC_RST);
    PRESC_WR <= 1'b1;
    PRESC_WDATA <= 20'h00000;
    @(posedge CORE_CLK) PRESC_WR <= 1'b0;
    tick(0, 1);
    chk({SEC, 7'h00, CAL_OUT}, 16'h0100);
    CLK_SEL <= CSEL_FAST_DIV;
    tick(0, 1);
    tick(2, 127);
    chk(SEC, 8'h01);
    tick(2, 1);
    chk(SEC, 8'h02);
    CLK_SEL <= CSEL_LOW_RC;
    tick(1, 1);
    chk(SEC, 8'h03);
    // Mains reference: 50 and then 60 reference ticks make one second.
    REF_EN <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      REF_60HZ <= (r == 1);
      tick(3, 49 + 10 * r);
      chk(SEC, 8'h03 + 8'(r));
      tick(3, 1);
      chk(SEC, 8'h04 + 8'(r));
    end
    REF_EN <= 1'b0;
    CLK_SEL <= CSEL_SLOW_XTAL;
    cal(24'h095959, 4'h3, 24'h280201, 24'h100000, 4'h3, 24'h280201);
    cal(24'h235959, 4'h3, 24'h280201, 24'h000000, 4'h4, 24'h010301);
    cal(24'h235959, 4'h3, 24'h280204, 24'h000000, 4'h4, 24'h290204);
    cal(24'h235959, 4'h3, 24'h290204, 24'h000000, 4'h4, 24'h010304);
    cal(24'h235959, 4'h3, 24'h300405, 24'h000000, 4'h4, 24'h010505);
    cal(24'h235959, 4'h3, 24'h300505, 24'h000000, 4'h4, 24'h310505);
    cal(24'h235959, 4'h7, 24'h311299, 24'h000000, 4'h1, 24'h010100);
    FMT_12H <= 1'b1;
    cal(24'h115959, 4'hB, 24'h100605, 24'h120000, 4'h4, 24'h110605);
    cal(24'h115959, 4'h3, 24'h100605, 24'h120000, 4'hB, 24'h100605);
    cal(24'h125959, 4'h3, 24'h100605, 24'h010000, 4'h3, 24'h100605);
    FMT_12H <= 1'b0;
    // Alarm A compares seconds only; alarm B compares every field.
    ALMA_SEC_MIN <= 16'h0005;
    ALMA_MASK <= MSK_MIN | MSK_HOUR | MSK_DATE;
    ALM_EN <= 2'h1;
    STOP_MODE <= 1'b1;
    clr();
    cal(24'h102004, 4'h1, 24'h150101, 24'h102005, 4'h1, 24'h150101);
    chk(ev_seen, 5'h01 << EV_ALMA);
    chk(stop_seen, 1'b1);
    clr();
    tick(0, 1);
    chk({ev_seen, stop_seen}, 6'h00);
    ALMB_SEC_MIN <= 16'h3010;
    ALMB_PM_HOUR_DATE <= {1'b0, 8'h12, 8'h15};
    ALM_EN <= 2'h2;
    {STOP_MODE, STANDBY_MODE, BATTERY_MODE} <= 3'h3;
    clr();
    cal(24'h123009, 4'h1, 24'h160101, 24'h123010, 4'h1, 24'h160101);
    chk(ev_seen, 5'h00);
    clr();
    cal(24'h123009, 4'h1, 24'h150101, 24'h123010, 4'h1, 24'h150101);
    chk(ev_seen, 5'h01 << EV_ALMB);
    chk({sbx_seen, stop_seen}, 2'h0);
    BATTERY_MODE <= 1'b0;
    ALM_EN <= 2'h0;
    for (int i = 0; i < 5; i++) begin
      clr();
      {INDEPENDENT_WATCHDOG_RST, EXTERNAL_RESET_PIN, WAKEUP_PIN, TSTAMP_IN, TAMPER_IN} <= 5'h01 << i;
      cyc(4);
      chk(sbx_seen, 1'b1);
      chk(ev_seen, (i < 2) ? (5'h01 << (EV_TAMPER + i)) : 5'h00);
      {INDEPENDENT_WATCHDOG_RST, EXTERNAL_RESET_PIN, WAKEUP_PIN, TSTAMP_IN, TAMPER_IN} <= 5'h00;
      cyc(2);
    end
    {STOP_MODE, STANDBY_MODE} <= 2'h2;
    WUT_SEL <= WSEL_SEC;
    WUT_RELOAD <= 16'h0001;
    WUT_EN <= 1'b1;
    cyc(3);
    clr();
    tick(0, 8);
    chk(wake_cnt, 4);
    chk({ev_seen, stop_seen}, 6'h09);
    chk(SEC, 8'h18);
    // Divided resolutions: four counter steps give two wakeup events.
    for (int m = 0; m < 4; m++) begin
      WUT_SEL <= 3'(m);
      clr();
      tick(0, 64 >> m);
      chk(wake_cnt, 2);
    end
    {WUT_EN, STOP_MODE} <= 2'h0;
    acc(1'b0, 1'b1, 10'h000, 32'hA5A5_5A5A);
    acc(1'b0, 1'b1, 10'h013, 32'h1234_5678);
    acc(1'b0, 1'b1, 10'h014, 32'hFFFF_FFFF);
    acc(1'b0, 1'b0, 10'h014, 32'h0);
    chk(BKP_RDATA, 32'h0);
    acc(1'b1, 1'b1, 10'h005, 32'hDEAD_BEEF);
    acc(1'b1, 1'b0, 10'h005, 32'h0);
    chk({SRAM_ENABLED, SRAM_RDATA}, 33'h0);
    sram_ctl(1'b1, 1'b1);
    acc(1'b1, 1'b1, 10'h3FF, 32'hDEAD_BEEF);
    STANDBY_MODE <= 1'b1;
    cyc(4);
    STANDBY_MODE <= 1'b0;
    acc(1'b1, 1'b0, 10'h3FF, 32'h0);
    chk({SRAM_ENABLED, SRAM_RDATA}, {1'b1, 32'hDEAD_BEEF});
    sram_ctl(1'b0, 1'b1);
    acc(1'b1, 1'b0, 10'h3FF, 32'h0);
    chk({SRAM_ENABLED, SRAM_RDATA}, 33'h0);
    acc(1'b1, 1'b1, 10'h3FF, 32'h0BAD_F00D);
    sram_ctl(1'b1, 1'b0);
    acc(1'b1, 1'b0, 10'h3FF, 32'h0);
    chk(SRAM_RDATA, 32'hDEAD_BEEF);
    do_reset();
    chk_rst();
    acc(1'b0, 1'b0, 10'h000, 32'h0);
    chk(BKP_RDATA, 32'hA5A5_5A5A);
    acc(1'b0, 1'b0, 10'h013, 32'h0);
    chk(BKP_RDATA, 32'h1234_5678);
    report_and_stop();
  end
endmodule
`default_nettype wire
